/* File: src/hpc_playback_control.v */
// Function
// - Fire starts sequencer playback, or calibration or diagnostics in those modes.
// - Trigger bit stays set during playback; the device clears it at sequence end, on standby or on overcurrent.
// - Host clearing trigger bit during playback aborts the sequence at once.
// - In external edge mode a rising pin edge sets the trigger bit; in level mode the bit follows the pin.
// - Streaming modes assert fire without changing the readable trigger bit.
// - Linear actuator open loop toggles outputs at configured frequency regardless of load.
// - Regulator short shuts down; restart with all registers at defaults.
// - Output short during a process sets overcurrent flag and cuts current.
// - Output shorts are checked only during processes; idle shorts wait for next attempt.
// - Linear actuator drive period field seeds the resonance tracker half period.
// - Rotating mass drive period field sets back-EMF sampling interval.
// - Dissipation field sets current decay time before tristating outputs.
// - Blanking field sets settling time before back-EMF conversion.
// - Closed loop uses steady drive level as target.
// - Open loop ignores steady level and uses peak limit as full scale.
// - Overdrive and braking are bounded by peak limit, which beats steady level.
// - Linear actuator peak limit sets maximum peak output independent of timing.
// - Level trigger mode: bit follows pin, falling edge cancels sequence.
// - Standby stops playback at once, keeping registers and bus access.
`include "hpc_map.vh"

module hpc_playback_control #(
    parameter [31:0] DRIVE_STEP_CYCLES = `HPC_DRIVE_STEP_NS / `HPC_CLK_PERIOD_NS,
    parameter [31:0] DECAY_STEP_CYCLES = `HPC_DECAY_STEP_NS / `HPC_CLK_PERIOD_NS,
    parameter [31:0] BLANK_STEP_CYCLES = `HPC_BLANK_STEP_NS / `HPC_CLK_PERIOD_NS,
    parameter [31:0] EFFECT_CYCLES = `HPC_EFFECT_NS / `HPC_CLK_PERIOD_NS,
    parameter [31:0] PROCESS_CYCLES = `HPC_PROCESS_NS / `HPC_CLK_PERIOD_NS
) (
    input wire i_core_clk,
    input wire i_resetn,
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [7:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    input wire i_external_trigger_pin,
    input wire i_output_short,
    input wire i_regulator_short,
    input wire i_overdrive,
    input wire i_zero_cross_early,
    input wire i_zero_cross_late,
    output reg [7:0] o_reg_rdata,
    output reg [1:0] o_process_state,
    output reg [7:0] o_waveform_id,
    output reg o_drive_enable,
    output reg [7:0] o_drive_level,
    output reg o_out_hiz,
    output reg o_out_polarity,
    output reg o_bemf_convert,
    output reg [5:0] o_half_period,
    output reg o_overcurrent_flag,
    output reg o_shutdown
);
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_PLAY = 2'h1;
    localparam [1:0] ST_CAL = 2'h2;
    localparam [1:0] ST_DIAG = 2'h3;
    localparam [1:0] PH_DRIVE = 2'h0;
    localparam [1:0] PH_DECAY = 2'h1;
    localparam [1:0] PH_BLANK = 2'h2;
    localparam [2:0] SEQ_LAST = 3'h7;
    localparam [5:0] HALF_MAX = 6'h3F;

    reg [1:0] trig_sync;
    reg [1:0] short_sync;
    reg [1:0] regshort_sync;
    reg trig_prev;
    reg dev_reset_pend;
    reg [7:0] mode_reg;
    reg [7:0] steady_drive_level;
    reg [7:0] peak_limit_level;
    reg [7:0] act_type_reg;
    reg [7:0] period_reg;
    reg [7:0] sense_reg;
    reg [7:0] loop_reg;
    reg [7:0] seq_mem [0:7];
    reg playback_trigger;
    reg overcurrent_flag;
    reg [1:0] state;
    reg [2:0] seq_idx;
    reg [31:0] proc_timer;
    reg [1:0] phase;
    reg [31:0] ph_timer;
    reg [5:0] half_period;
    reg polarity;
    integer k;

    // Regulator short or the self-clearing reset bit restores every default.
    wire soft_rst = !i_resetn || regshort_sync[1] || dev_reset_pend;
    wire [2:0] mode = mode_reg[2:0];
    wire standby = mode_reg[`HPC_STANDBY_BIT];
    wire is_lra = act_type_reg[`HPC_LRA_BIT];
    wire open_loop = is_lra ? loop_reg[`HPC_OL_LRA_BIT] : loop_reg[`HPC_OL_ERM_BIT];
    wire streaming = (mode == `HPC_MODE_PWM_ANALOG) || (mode == `HPC_MODE_AUDIO) ||
        (mode == `HPC_MODE_REALTIME);
    wire fire = playback_trigger || streaming;
    wire active = state != ST_IDLE;
    wire [7:0] seq_off = i_reg_addr - `HPC_ADDR_SEQ_FIRST;
    wire seq_hit = (i_reg_addr >= `HPC_ADDR_SEQ_FIRST) && (i_reg_addr <= `HPC_ADDR_SEQ_LAST);
    wire host_trig_wr = i_reg_wr && (i_reg_addr == `HPC_ADDR_TRIGGER);
    wire [7:0] cur_id = seq_mem[seq_idx];
    wire oc_set = short_sync[1] && active;
    wire seq_done = (state == ST_PLAY) && !streaming &&
        ((cur_id == 8'h00) || ((proc_timer == 32'h0) && (seq_idx == SEQ_LAST)));
    wire proc_done = ((state == ST_CAL) || (state == ST_DIAG)) && (proc_timer == 32'h0);
    wire finish = seq_done || proc_done;
    // Peak limit wins over the steady level and bounds overdrive and braking.
    wire [7:0] closed_level = (i_overdrive || (steady_drive_level > peak_limit_level)) ?
        peak_limit_level : steady_drive_level;
    wire [7:0] drive_level = open_loop ? peak_limit_level : closed_level;
    wire [31:0] drive_load = half_period * DRIVE_STEP_CYCLES - 32'h1;
    wire [31:0] decay_load = {30'h0, sense_reg[1:0]} * DECAY_STEP_CYCLES + DECAY_STEP_CYCLES - 32'h1;
    wire [31:0] blank_load = {30'h0, sense_reg[3:2]} * BLANK_STEP_CYCLES + BLANK_STEP_CYCLES - 32'h1;

    always @(posedge i_core_clk) begin
        if (!i_resetn) begin
            trig_sync <= 2'h0;
            short_sync <= 2'h0;
            regshort_sync <= 2'h0;
        end else begin
            trig_sync <= {trig_sync[0], i_external_trigger_pin};
            short_sync <= {short_sync[0], i_output_short};
            regshort_sync <= {regshort_sync[0], i_regulator_short};
        end
    end

    // Register file.
    always @(posedge i_core_clk) begin
        if (soft_rst) begin
            dev_reset_pend <= 1'b0;
            mode_reg <= `HPC_MODE_RST;
            steady_drive_level <= `HPC_STEADY_RST;
            peak_limit_level <= `HPC_PEAK_RST;
            act_type_reg <= `HPC_ACT_RST;
            period_reg <= `HPC_PERIOD_RST;
            sense_reg <= `HPC_SENSE_RST;
            loop_reg <= `HPC_LOOP_RST;
            for (k = 0; k < 8; k = k + 1) begin
                seq_mem[k] <= 8'h00;
            end
        end else if (i_reg_wr) begin
            if (seq_hit) begin
                seq_mem[seq_off[2:0]] <= i_reg_wdata;
            end
            case (i_reg_addr)
                `HPC_ADDR_MODE: begin
                    mode_reg <= {1'b0, i_reg_wdata[6:0]};
                    dev_reset_pend <= i_reg_wdata[`HPC_DEV_RESET_BIT];
                end
                `HPC_ADDR_STEADY: steady_drive_level <= i_reg_wdata;
                `HPC_ADDR_PEAK: peak_limit_level <= i_reg_wdata;
                `HPC_ADDR_ACT_TYPE: act_type_reg <= i_reg_wdata;
                `HPC_ADDR_PERIOD: period_reg <= {3'h0, i_reg_wdata[4:0]};
                `HPC_ADDR_SENSE: sense_reg <= {4'h0, i_reg_wdata[3:0]};
                `HPC_ADDR_LOOP: loop_reg <= i_reg_wdata;
                default: ;
            endcase
        end
    end

    // Trigger bit; later assignments win, so a set beats a same-cycle clear.
    always @(posedge i_core_clk) begin
        if (soft_rst) begin
            playback_trigger <= 1'b0;
            trig_prev <= 1'b0;
        end else begin
            trig_prev <= trig_sync[1];
            if (mode == `HPC_MODE_EXT_LEVEL) begin
                playback_trigger <= trig_sync[1] && !standby;
            end else begin
                if (finish || standby || oc_set) begin
                    playback_trigger <= 1'b0;
                end
                if (host_trig_wr) begin
                    playback_trigger <= i_reg_wdata[`HPC_TRIG_BIT];
                end
                if ((mode == `HPC_MODE_EXT_EDGE) && trig_sync[1] && !trig_prev && !standby) begin
                    playback_trigger <= 1'b1;
                end
            end
        end
    end

    // Overcurrent flag holds while the short stays present.
    always @(posedge i_core_clk) begin
        if (soft_rst) begin
            overcurrent_flag <= 1'b0;
        end else begin
            overcurrent_flag <= short_sync[1] && (overcurrent_flag || active);
        end
    end

    // Process sequencing.
    always @(posedge i_core_clk) begin
        if (soft_rst) begin
            state <= ST_IDLE;
            seq_idx <= 3'h0;
            proc_timer <= 32'h0;
        end else if (active && (!fire || standby || overcurrent_flag || finish)) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    seq_idx <= 3'h0;
                    if (fire && !standby) begin
                        if (mode == `HPC_MODE_CAL) begin
                            state <= ST_CAL;
                            proc_timer <= PROCESS_CYCLES - 32'h1;
                        end else if (mode == `HPC_MODE_DIAG) begin
                            state <= ST_DIAG;
                            proc_timer <= PROCESS_CYCLES - 32'h1;
                        end else begin
                            state <= ST_PLAY;
                            proc_timer <= EFFECT_CYCLES - 32'h1;
                        end
                    end
                end
                ST_PLAY: begin
                    if (!streaming) begin
                        if (proc_timer == 32'h0) begin
                            seq_idx <= seq_idx + 3'h1;
                            proc_timer <= EFFECT_CYCLES - 32'h1;
                        end else begin
                            proc_timer <= proc_timer - 32'h1;
                        end
                    end
                end
                ST_CAL, ST_DIAG: proc_timer <= proc_timer - 32'h1;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Drive, decay and blanking cycle around each back-EMF sample.
    always @(posedge i_core_clk) begin
        if (soft_rst) begin
            phase <= PH_DRIVE;
            ph_timer <= 32'h0;
            half_period <= 6'h01;
            polarity <= 1'b0;
            o_bemf_convert <= 1'b0;
        end else if (!active) begin
            phase <= PH_DRIVE;
            half_period <= period_reg[5:0] + 6'h01;
            ph_timer <= {26'h0, period_reg[5:0] + 6'h01} * DRIVE_STEP_CYCLES - 32'h1;
            polarity <= 1'b0;
            o_bemf_convert <= 1'b0;
        end else begin
            o_bemf_convert <= 1'b0;
            if (ph_timer != 32'h0) begin
                ph_timer <= ph_timer - 32'h1;
            end else begin
                case (phase)
                    PH_DRIVE: begin
                        if (open_loop) begin
                            polarity <= polarity ^ is_lra;
                            ph_timer <= drive_load;
                        end else begin
                            phase <= PH_DECAY;
                            ph_timer <= decay_load;
                        end
                    end
                    PH_DECAY: begin
                        phase <= PH_BLANK;
                        ph_timer <= blank_load;
                    end
                    default: begin
                        phase <= PH_DRIVE;
                        o_bemf_convert <= 1'b1;
                        polarity <= polarity ^ is_lra;
                        if (is_lra && i_zero_cross_early && (half_period > 6'h01)) begin
                            half_period <= half_period - 6'h01;
                            ph_timer <= drive_load - DRIVE_STEP_CYCLES;
                        end else if (is_lra && i_zero_cross_late && (half_period < HALF_MAX)) begin
                            half_period <= half_period + 6'h01;
                            ph_timer <= drive_load + DRIVE_STEP_CYCLES;
                        end else begin
                            ph_timer <= drive_load;
                        end
                    end
                endcase
            end
        end
    end

    // Registered outputs.
    always @(posedge i_core_clk) begin
        if (soft_rst) begin
            o_reg_rdata <= 8'h00;
            o_process_state <= ST_IDLE;
            o_waveform_id <= 8'h00;
            o_drive_enable <= 1'b0;
            o_drive_level <= 8'h00;
            o_out_hiz <= 1'b1;
            o_out_polarity <= 1'b0;
            o_half_period <= 6'h01;
            o_overcurrent_flag <= 1'b0;
            o_shutdown <= 1'b1;
        end else begin
            o_process_state <= state;
            o_waveform_id <= ((state == ST_PLAY) && !streaming) ? cur_id : 8'h00;
            o_drive_enable <= active && !overcurrent_flag && !standby;
            o_drive_level <= (active && !overcurrent_flag && (phase == PH_DRIVE)) ? drive_level : 8'h00;
            o_out_hiz <= !active || (phase == PH_BLANK);
            o_out_polarity <= polarity;
            o_half_period <= half_period;
            o_overcurrent_flag <= overcurrent_flag;
            o_shutdown <= overcurrent_flag || standby;
            if (i_reg_rd) begin
                if (seq_hit) begin
                    o_reg_rdata <= seq_mem[seq_off[2:0]];
                end else begin
                    case (i_reg_addr)
                        `HPC_ADDR_STATUS: o_reg_rdata <= {7'h00, overcurrent_flag};
                        `HPC_ADDR_MODE: o_reg_rdata <= mode_reg;
                        `HPC_ADDR_TRIGGER: o_reg_rdata <= {7'h00, playback_trigger};
                        `HPC_ADDR_STEADY: o_reg_rdata <= steady_drive_level;
                        `HPC_ADDR_PEAK: o_reg_rdata <= peak_limit_level;
                        `HPC_ADDR_ACT_TYPE: o_reg_rdata <= act_type_reg;
                        `HPC_ADDR_PERIOD: o_reg_rdata <= period_reg;
                        `HPC_ADDR_SENSE: o_reg_rdata <= sense_reg;
                        `HPC_ADDR_LOOP: o_reg_rdata <= loop_reg;
                        default: o_reg_rdata <= 8'h00;
                    endcase
                end
            end
        end
    end
endmodule // hpc_playback_control

/* File: src/hpc_map.vh */
`ifndef HPC_MAP_VH
`define HPC_MAP_VH

// Register addresses.
`define HPC_ADDR_STATUS 8'h00
`define HPC_ADDR_MODE 8'h01
`define HPC_ADDR_SEQ_FIRST 8'h04
`define HPC_ADDR_SEQ_LAST 8'h0B
`define HPC_ADDR_TRIGGER 8'h0C
`define HPC_ADDR_STEADY 8'h16
`define HPC_ADDR_PEAK 8'h17
`define HPC_ADDR_ACT_TYPE 8'h1A
`define HPC_ADDR_PERIOD 8'h1B
`define HPC_ADDR_SENSE 8'h1C
`define HPC_ADDR_LOOP 8'h1D

// Field positions.
`define HPC_OC_BIT 0
`define HPC_TRIG_BIT 0
`define HPC_STANDBY_BIT 6
`define HPC_DEV_RESET_BIT 7
`define HPC_LRA_BIT 7
`define HPC_OL_LRA_BIT 0
`define HPC_OL_ERM_BIT 5

// Reset values.
`define HPC_MODE_RST 8'h40
`define HPC_STEADY_RST 8'h3F
`define HPC_PEAK_RST 8'h89
`define HPC_ACT_RST 8'h00
`define HPC_PERIOD_RST 8'h13
`define HPC_SENSE_RST 8'h05
`define HPC_LOOP_RST 8'h00

// Operating modes.
`define HPC_MODE_INTERNAL 3'h0
`define HPC_MODE_EXT_EDGE 3'h1
`define HPC_MODE_EXT_LEVEL 3'h2
`define HPC_MODE_PWM_ANALOG 3'h3
`define HPC_MODE_AUDIO 3'h4
`define HPC_MODE_REALTIME 3'h5
`define HPC_MODE_DIAG 3'h6
`define HPC_MODE_CAL 3'h7

// Timing, in nanoseconds.
`define HPC_CLK_PERIOD_NS 10
`define HPC_DRIVE_STEP_NS 100000
`define HPC_DECAY_STEP_NS 50000
`define HPC_BLANK_STEP_NS 25000
`define HPC_EFFECT_NS 100000000
`define HPC_PROCESS_NS 200000000

`endif

/* File: tb/hpc_playback_props.sv */
module hpc_playback_props (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_output_short,
    input wire logic i_regulator_short,
    input wire logic [1:0] o_process_state,
    input wire logic o_drive_enable,
    input wire logic [7:0] o_drive_level,
    input wire logic o_out_hiz,
    input wire logic o_bemf_convert,
    input wire logic o_overcurrent_flag,
    input wire logic o_shutdown
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_resetn);
    a_idle_no_drive: assert property (o_process_state == 2'h0 |-> !o_drive_enable && o_drive_level == 8'h00)
        else $error("drive active while idle");
    a_oc_only_active: assert property ($rose(o_overcurrent_flag) |-> $past(o_process_state) != 2'h0)
        else $error("overcurrent flagged while idle");
    a_oc_cuts_drive: assert property (o_overcurrent_flag |=> !o_drive_enable)
        else $error("drive still enabled under overcurrent");
    a_oc_flag_holds: assert property (o_overcurrent_flag && i_output_short |=> o_overcurrent_flag)
        else $error("overcurrent flag dropped while short present");
    a_reg_short_down: assert property (i_regulator_short [*4] |=> o_shutdown && o_process_state == 2'h0)
        else $error("no shutdown on regulator short");
    a_trig_clear_abort: assert property (i_reg_wr && i_reg_addr == 8'h0C && !i_reg_wdata[0]
        && o_process_state == 2'h1 |-> ##[1:3] o_process_state == 2'h0)
        else $error("trigger clear did not abort");
    a_standby_stops: assert property (i_reg_wr && i_reg_addr == 8'h01 && i_reg_wdata[6]
        |-> ##[1:3] o_process_state == 2'h0)
        else $error("standby did not stop playback");
    a_convert_after_blank: assert property ($rose(o_bemf_convert) |-> $past(o_out_hiz) ##1 !o_bemf_convert)
        else $error("conversion without blanking");
    c_cal: cover property (o_process_state == 2'h2);
    c_diag: cover property (o_process_state == 2'h3);
    c_convert: cover property (o_bemf_convert);
endmodule // hpc_playback_props

bind hpc_playback_control hpc_playback_props u_hpc_playback_props (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
    .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_output_short(i_output_short),
    .i_regulator_short(i_regulator_short), .o_process_state(o_process_state), .o_drive_enable(o_drive_enable),
    .o_drive_level(o_drive_level), .o_out_hiz(o_out_hiz), .o_bemf_convert(o_bemf_convert),
    .o_overcurrent_flag(o_overcurrent_flag), .o_shutdown(o_shutdown));

/* File: tb/hpc_host_model.sv */
module hpc_host_model (
    input wire logic i_core_clk,
    input wire logic [7:0] i_reg_rdata,
    output logic o_reg_wr,
    output logic o_reg_rd,
    output logic [7:0] o_reg_addr,
    output logic [7:0] o_reg_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_addr = 8'h00;
        o_reg_wdata = 8'h00;
    end
    // One-cycle write strobe; data shows its inverse once released.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        o_reg_wr <= 1'b1;
        o_reg_addr <= a;
        o_reg_wdata <= d;
        @(posedge i_core_clk);
        o_reg_wr <= 1'b0;
        o_reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_core_clk);
        o_reg_rd <= 1'b1;
        o_reg_addr <= a;
        @(posedge i_core_clk);
        o_reg_rd <= 1'b0;
        @(posedge i_core_clk);
        #1;
        d = i_reg_rdata;
    endtask
endmodule // hpc_host_model

/* File: tb/hpc_playback_control_tb_top.sv */
module hpc_playback_control_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_core_clk, i_resetn, i_reg_wr, i_reg_rd, i_overdrive, i_zero_cross_early, i_zero_cross_late;
    logic i_external_trigger_pin, i_output_short, i_regulator_short, o_drive_enable, o_out_hiz, p;
    logic o_out_polarity, o_bemf_convert, o_overcurrent_flag, o_shutdown;
    logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, o_waveform_id, o_drive_level, rv;
    logic [1:0] o_process_state, zc_prev;
    logic [5:0] o_half_period;
    int bad_count, comparisons, n, i, mdl[int];
    int dflt[9] = '{8'h01, 8'h16, 8'h17, 8'h1B, 8'h1C, 8'h1D, 8'h1A, 8'h0C, 8'h00};
    hpc_playback_control #(.DRIVE_STEP_CYCLES(4), .DECAY_STEP_CYCLES(2), .BLANK_STEP_CYCLES(2),
        .EFFECT_CYCLES(20), .PROCESS_CYCLES(30)) u_hpc_playback_control (.i_core_clk(i_core_clk),
        .i_resetn(i_resetn), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .i_external_trigger_pin(i_external_trigger_pin),
        .i_output_short(i_output_short), .i_regulator_short(i_regulator_short), .i_overdrive(i_overdrive),
        .i_zero_cross_early(i_zero_cross_early), .i_zero_cross_late(i_zero_cross_late),
        .o_reg_rdata(o_reg_rdata), .o_process_state(o_process_state), .o_waveform_id(o_waveform_id),
        .o_drive_enable(o_drive_enable), .o_drive_level(o_drive_level), .o_out_hiz(o_out_hiz),
        .o_out_polarity(o_out_polarity), .o_bemf_convert(o_bemf_convert), .o_half_period(o_half_period),
        .o_overcurrent_flag(o_overcurrent_flag), .o_shutdown(o_shutdown));
    hpc_host_model u_hpc_host_model (.i_core_clk(i_core_clk), .i_reg_rdata(o_reg_rdata), .o_reg_wr(i_reg_wr),
        .o_reg_rd(i_reg_rd), .o_reg_addr(i_reg_addr), .o_reg_wdata(i_reg_wdata));
    initial begin
        i_core_clk = 1'b0;
        forever #5 i_core_clk = ~i_core_clk;
    end
    always @(posedge i_core_clk) begin
        zc_prev <= {i_zero_cross_early, i_zero_cross_late};
        {i_zero_cross_early, i_zero_cross_late} <= 2'($urandom_range(3, 0));
    end
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input int e);
        comparisons++;
        if (g !== e[7:0]) begin
            bad_count++;
            $display("Error %0t: got %h expected %h", $time, g, e[7:0]);
        end
    endtask
    task automatic tmo(input bit hit);
        if (hit) begin
            bad_count++;
            $display("Error %0t: wait timed out", $time);
            wrap_up();
        end
    endtask
    task automatic mreset();
        mdl.delete();
        mdl[8'h01] = 8'h40;
        mdl[8'h16] = 8'h3F;
        mdl[8'h17] = 8'h89;
        mdl[8'h1B] = 8'h13;
        mdl[8'h1C] = 8'h05;
    endtask
    task automatic wr(input int a, input int d);
        u_hpc_host_model.wr(a[7:0], d[7:0]);
        mdl[a] = d;
    endtask
    task automatic rdc(input int a);
        u_hpc_host_model.rd(a[7:0], rv);
        chk(rv, mdl.exists(a) ? mdl[a] : 0);
    endtask
    // Waits a bounded time for a process state; running out ends the run.
    task automatic wst(input logic [1:0] s, input int lim);
        n = 0;
        do begin
            @(posedge i_core_clk);
            #1;
            n++;
        end while (o_process_state !== s && n < lim);
        comparisons++;
        if (o_process_state !== s) begin
            bad_count++;
            $display("Error %0t: state %h not reached", $time, s);
            wrap_up();
        end
    endtask
    task automatic play(input int lvl);
        wr(8'h0C, 8'h01);
        wst(2'h1, 10);
        chk(o_waveform_id, mdl[4]);
        rdc(8'h0C);
        n = 0;
        while (o_drive_level === 8'h00 && n < 200) begin
            @(posedge i_core_clk);
            #1;
            n++;
        end
        tmo(n >= 200);
        chk(o_drive_level, lvl);
        wst(2'h0, 400);
        mdl[12] = 0;
        rdc(8'h0C);
    endtask
    initial begin
        void'($urandom(32'hB059));
        {i_resetn, i_external_trigger_pin, i_output_short, i_regulator_short, i_overdrive} = 5'h00;
        bad_count = 0;
        comparisons = 0;
        mreset();
        repeat (3) @(posedge i_core_clk);
        i_resetn <= 1'b1;
        foreach (dflt[k]) rdc(dflt[k]);
        u_hpc_host_model.wr(8'h30, 8'h5A);
        rdc(8'h30);
        wr(8'h01, 8'h00);
        for (i = 0; i < 4; i++) begin
            wr(8'h16, $urandom_range(255, 1));
            wr(8'h17, $urandom_range(255, 1));
            wr(8'h1D, (i == 3) ? 8'h20 : 8'h00);
            wr(8'h04, $urandom_range(255, 1));
            wr(8'h05, 8'h00);
            i_overdrive <= (i == 2);
            play((i >= 2) ? mdl[23] : (mdl[22] < mdl[23] ? mdl[22] : mdl[23]));
        end
        i_overdrive <= 1'b0;
        wr(8'h0C, 8'h01);
        wst(2'h1, 10);
        wr(8'h0C, 8'h00);
        wst(2'h0, 3);
        for (i = 3; i < 6; i++) begin
            wr(8'h01, i);
            wst(2'h1, 10);
            rdc(8'h0C);
            wr(8'h01, 8'h40);
            wst(2'h0, 4);
        end
        for (i = 6; i < 8; i++) begin
            wr(8'h01, i);
            wr(8'h0C, 8'h01);
            wst((i == 7) ? 2'h2 : 2'h3, 10);
            wst(2'h0, 60);
            mdl[12] = 0;
            rdc(8'h0C);
        end
        wr(8'h01, 8'h02);
        @(posedge i_core_clk) i_external_trigger_pin <= 1'b1;
        wst(2'h1, 10);
        mdl[12] = 1;
        rdc(8'h0C);
        @(posedge i_core_clk) i_external_trigger_pin <= 1'b0;
        wst(2'h0, 6);
        mdl[12] = 0;
        wr(8'h01, 8'h01);
        @(posedge i_core_clk) i_external_trigger_pin <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        i_external_trigger_pin <= 1'b0;
        wst(2'h1, 10);
        wst(2'h0, 60);
        wr(8'h01, 8'h00);
        @(posedge i_core_clk) i_output_short <= 1'b1;
        repeat (8) @(posedge i_core_clk);
        #1;
        chk(o_overcurrent_flag, 0);
        wr(8'h0C, 8'h01);
        repeat (6) @(posedge i_core_clk);
        #1;
        chk(o_overcurrent_flag, 1);
        chk(o_drive_enable, 0);
        chk(o_shutdown, 1);
        mdl[0] = 1;
        rdc(8'h00);
        @(posedge i_core_clk) i_output_short <= 1'b0;
        repeat (6) @(posedge i_core_clk);
        #1;
        chk(o_overcurrent_flag, 0);
        wr(8'h16, 8'h11);
        @(posedge i_core_clk) i_regulator_short <= 1'b1;
        repeat (6) @(posedge i_core_clk);
        i_regulator_short <= 1'b0;
        repeat (4) @(posedge i_core_clk);
        mreset();
        rdc(8'h16);
        rdc(8'h01);
        wr(8'h01, 8'h00);
        wr(8'h1B, 8'h01);
        wr(8'h1C, 8'h0D);
        for (i = 4; i < 7; i++) wr(i, $urandom_range(255, 1));
        wr(8'h0C, 8'h01);
        wst(2'h1, 10);
        chk(o_half_period, 2);
        n = 0;
        i = 0;
        // Decay cycles count one each, blanking cycles a hundred each.
        do begin
            @(posedge i_core_clk);
            #1;
            n++;
            if (o_process_state === 2'h1 && o_drive_level === 8'h00) i += (o_out_hiz === 1'b1) ? 100 : 1;
        end while (o_bemf_convert !== 1'b1 && n < 100);
        tmo(n >= 100);
        chk(i == 804, 1);
        wst(2'h0, 100);
        wr(8'h1A, 8'h80);
        wr(8'h1D, 8'h01);
        wr(8'h0C, 8'h01);
        wst(2'h1, 10);
        chk(o_half_period, 2);
        p = o_out_polarity;
        n = 0;
        repeat (32) begin
            @(posedge i_core_clk);
            #1;
            n += (o_out_polarity !== p);
            p = o_out_polarity;
        end
        chk(n, 4);
        wst(2'h0, 100);
        wr(8'h1D, 8'h00);
        wr(8'h0C, 8'h01);
        wst(2'h1, 10);
        n = 0;
        while (o_bemf_convert !== 1'b1 && n < 100) begin
            @(posedge i_core_clk);
            #1;
            n++;
        end
        tmo(n >= 100);
        // The tracker moves one step per sample, towards an early or a late zero crossing.
        rv = {6'h00, zc_prev};
        @(posedge i_core_clk);
        #1;
        chk(o_half_period, rv[1] ? 1 : (rv[0] ? 3 : 2));
        wst(2'h0, 100);
        wrap_up();
    end
endmodule // hpc_playback_control_tb_top
